// >>> can_filter_timing_consts.vh
// constants for the identifier filter, protection and bit-timing block
// assumes an APB master with 32-bit data; all registers are word aligned
`ifndef CAN_FILTER_TIMING_CONSTS_VH
`define CAN_FILTER_TIMING_CONSTS_VH

`define OFS_CONTROL_A 12'h000
`define OFS_CONTROL_B 12'h004
`define OFS_TIMING_A 12'h008
`define OFS_TIMING_B 12'h00C
`define OFS_RX_FLAG 12'h010
`define OFS_FILTER_MODE 12'h014
`define OFS_RX_ERR 12'h018
`define OFS_TX_ERR 12'h01C
`define OFS_STAMP 12'h020
`define OFS_PATTERN_LO 12'h040
`define OFS_PATTERN_HI 12'h044
`define OFS_MASK_LO 12'h048
`define OFS_MASK_HI 12'h04C

// control_reg_a fields
`define CA_INIT_REQ 0
`define CA_TIME_EN 3
// control_reg_b fields
`define CB_INIT_ACK 0
`define CB_CLK_SRC 6
`define CB_ENABLE 7
// bus_timing_reg_a: [5:0] prescaler-1, [7:6] jump width-1
// bus_timing_reg_b: [3:0] seg1-1, [6:4] seg2-1, [7] triple sampling
`define TB_SAMP 7
// filter mode control: [5:4] mode, [2:0] hit index
`define FM_32 2'h0
`define FM_16 2'h1
`define FM_8 2'h2
`define FM_CLOSED 2'h3

`define RST_CONTROL_A 8'h01
`define RST_CONTROL_B 8'h11
`define RST_TIMING 8'h00
`define RST_FILTER_MODE 8'h00

`endif

// >>> can_filter_timing.v
// identifier acceptance filter, configuration lock, bit timing and time stamp
// assumes a frame engine that presents a received id with a done strobe
`timescale 1ns/1ps
`include "can_filter_timing_consts.vh"

module can_filter_timing
(
	// clock and reset
	input wire i_ref_clk,
	input wire i_reset_n,
	// apb slave
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	output reg [31:0] o_prdata,
	output reg o_pready,
	output reg o_pslverr,
	// clocks, modes
	input wire i_osc_clk,
	input wire i_special_mode,
	input wire i_power_down,
	// frame engine side
	input wire [31:0] i_rx_id_word,
	input wire i_rx_frame_ok,
	input wire i_tx_frame_ok,
	input wire i_rx_buf_free,
	input wire i_tx_bit,
	input wire i_rx_line,
	input wire [7:0] i_rx_err_cnt,
	input wire [7:0] i_tx_err_cnt,
	input wire [15:0] i_timer,
	// outputs
	output reg o_tx_line,
	output reg o_rx_shift,
	output reg o_stamp_rx,
	output reg o_stamp_tx,
	output reg [15:0] o_stamp_value,
	output reg o_tq_tick,
	output reg o_sample_tick,
	output reg o_sync_seg,
	output reg o_rx_sample,
	output reg [2:0] o_jump_width_tq
);

	////////////////////////////////////////////////////////////////////////////
	// registers
	reg [7:0] control_a_ff;
	reg [7:0] control_b_ff;
	reg enable_written_ff;
	reg [7:0] timing_a_ff;
	reg [7:0] timing_b_ff;
	reg [7:0] filter_mode_ff;
	reg [63:0] pattern_ff;
	reg [63:0] mask_ff;
	reg rx_full_ff;
	reg [15:0] stamp_ff;
	wire init_locked_open;
	wire wr_en;
	wire rd_en;
	wire rx_clear;

	assign wr_en = i_psel & i_penable & i_pwrite;
	assign rd_en = i_psel & i_penable & ~i_pwrite;
	assign init_locked_open = control_a_ff[`CA_INIT_REQ] & control_b_ff[`CB_INIT_ACK];
	assign rx_clear = wr_en & (i_paddr == `OFS_RX_FLAG) & i_pwdata[0];

	////////////////////////////////////////////////////////////////////////////
	// acceptance filter
	reg [7:0] hit_vec;
	reg [2:0] hit_idx;
	reg hit_any;
	integer k;
	wire [63:0] pat_bank;
	wire [63:0] msk_bank;
	wire [7:0] byte_hit;
	// bank order: pattern bytes 0..3 on top, bytes 4..7 below
	assign pat_bank = {pattern_ff[31:0], pattern_ff[63:32]};
	assign msk_bank = {mask_ff[31:0], mask_ff[63:32]};
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1)
		begin : g_byte
			assign byte_hit[g] = (((i_rx_id_word[31:24] ^ pat_bank[63-8*g -: 8]) & ~msk_bank[63-8*g -: 8])
				== 8'h00);
		end
	endgenerate
	wire [31:0] diff;
	assign diff = (i_rx_id_word ^ pattern_ff[31:0]) & ~mask_ff[31:0];
	wire [31:0] diff_hi;
	assign diff_hi = (i_rx_id_word ^ pattern_ff[63:32]) & ~mask_ff[63:32];

	always @*
	begin
		hit_vec = 8'h00;
		case (filter_mode_ff[5:4])
			`FM_32:
			begin
				// id word laid out as pattern bytes 0..3, msb first
				hit_vec[0] = (diff == 32'h0);
				hit_vec[1] = (diff_hi == 32'h0);
			end
			`FM_16:
			begin
				hit_vec[0] = (diff[31:16] == 16'h0);
				hit_vec[1] = (((i_rx_id_word[31:16] ^ pattern_ff[15:0]) & ~mask_ff[15:0]) == 16'h0);
				hit_vec[2] = (diff_hi[31:16] == 16'h0);
				hit_vec[3] = (((i_rx_id_word[31:16] ^ pattern_ff[47:32]) & ~mask_ff[47:32]) == 16'h0);
			end
			`FM_8:
			begin
				hit_vec = byte_hit;
			end
			default:
			begin
				hit_vec = 8'h00;
			end
		endcase
	end

	always @*
	begin
		hit_idx = 3'h0;
		hit_any = 1'b0;
		for (k = 7; k >= 0; k = k - 1)
		begin
			if (hit_vec[k])
			begin
				hit_idx = k[2:0];
				hit_any = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// apb register file
	wire accept;
	assign accept = i_rx_frame_ok & hit_any & i_rx_buf_free & ~rx_full_ff;

	always @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			control_a_ff <= `RST_CONTROL_A;
			control_b_ff <= `RST_CONTROL_B;
			enable_written_ff <= 1'b0;
			timing_a_ff <= `RST_TIMING;
			timing_b_ff <= `RST_TIMING;
			filter_mode_ff <= `RST_FILTER_MODE;
			pattern_ff <= 64'h0;
			mask_ff <= 64'h0;
			rx_full_ff <= 1'b0;
			o_prdata <= 32'h0;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end
		else
		begin
			o_pready <= i_psel & ~i_penable;
			o_pslverr <= 1'b0;
			if (accept)
				rx_full_ff <= 1'b1;
			else if (rx_clear)
				rx_full_ff <= 1'b0;
			if (accept)
				filter_mode_ff[2:0] <= hit_idx;
			if (wr_en && o_pready)
			begin
				case (i_paddr)
					`OFS_CONTROL_A: control_a_ff <= {i_pwdata[7:1], i_pwdata[0]};
					`OFS_CONTROL_B:
					begin
						if (init_locked_open)
						begin
							control_b_ff[6:1] <= i_pwdata[6:1];
							if (i_special_mode || !enable_written_ff)
								control_b_ff[`CB_ENABLE] <= i_pwdata[`CB_ENABLE];
							enable_written_ff <= 1'b1;
						end
					end
					`OFS_TIMING_A: if (init_locked_open) timing_a_ff <= i_pwdata[7:0];
					`OFS_TIMING_B: if (init_locked_open) timing_b_ff <= i_pwdata[7:0];
					`OFS_FILTER_MODE: if (init_locked_open) filter_mode_ff[5:4] <= i_pwdata[5:4];
					`OFS_PATTERN_LO: if (init_locked_open) pattern_ff[31:0] <= i_pwdata;
					`OFS_PATTERN_HI: if (init_locked_open) pattern_ff[63:32] <= i_pwdata;
					`OFS_MASK_LO: if (init_locked_open) mask_ff[31:0] <= i_pwdata;
					`OFS_MASK_HI: if (init_locked_open) mask_ff[63:32] <= i_pwdata;
					default: o_pslverr <= 1'b0;
				endcase
			end
			// init acknowledge follows the request
			control_b_ff[`CB_INIT_ACK] <= control_a_ff[`CA_INIT_REQ];
			if (rd_en && o_pready)
				o_prdata <= 32'h0;
			else if (i_psel && !i_penable)
			begin
				case (i_paddr)
					`OFS_CONTROL_A: o_prdata <= {24'h0, control_a_ff};
					`OFS_CONTROL_B: o_prdata <= {24'h0, control_b_ff};
					`OFS_TIMING_A: o_prdata <= {24'h0, timing_a_ff};
					`OFS_TIMING_B: o_prdata <= {24'h0, timing_b_ff};
					`OFS_RX_FLAG: o_prdata <= {31'h0, rx_full_ff};
					`OFS_FILTER_MODE: o_prdata <= {24'h0, filter_mode_ff};
					`OFS_RX_ERR: o_prdata <= {24'h0, i_rx_err_cnt};
					`OFS_TX_ERR: o_prdata <= {24'h0, i_tx_err_cnt};
					`OFS_STAMP: o_prdata <= {16'h0, stamp_ff};
					`OFS_PATTERN_LO: o_prdata <= pattern_ff[31:0];
					`OFS_PATTERN_HI: o_prdata <= pattern_ff[63:32];
					`OFS_MASK_LO: o_prdata <= mask_ff[31:0];
					`OFS_MASK_HI: o_prdata <= mask_ff[63:32];
					default: o_prdata <= 32'h0;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// clock source, prescaler and bit timing
	reg [2:0] osc_sync_ff;
	reg [2:0] rx_sync_ff;
	reg osc_level_ff;
	reg rx_level_ff;
	reg [5:0] presc_ff;
	reg [4:0] tq_cnt_ff;
	reg [2:0] samp_hist_ff;
	wire src_tick;
	wire [4:0] seg1_end;
	wire [4:0] bit_end;

	// with CB_CLK_SRC clear the oscillator is sampled on the reference clock and a rising edge is one protocol clock; set, every reference clock is one
	assign src_tick = control_b_ff[`CB_CLK_SRC] ? 1'b1 : (osc_sync_ff[2] & osc_sync_ff[1] & ~osc_level_ff);
	assign seg1_end = {1'b0, timing_b_ff[3:0]} + 5'h1;
	assign bit_end = seg1_end + {2'h0, timing_b_ff[6:4]} + 5'h1;

	always @(posedge i_ref_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			osc_sync_ff <= 3'h0;
			rx_sync_ff <= 3'h7;
			osc_level_ff <= 1'b0;
			rx_level_ff <= 1'b1;
			presc_ff <= 6'h0;
			tq_cnt_ff <= 5'h0;
			samp_hist_ff <= 3'h7;
			o_tq_tick <= 1'b0;
			o_sample_tick <= 1'b0;
			o_sync_seg <= 1'b0;
			o_rx_sample <= 1'b1;
			o_jump_width_tq <= 3'h1;
			o_tx_line <= 1'b1;
			o_rx_shift <= 1'b0;
			o_stamp_rx <= 1'b0;
			o_stamp_tx <= 1'b0;
			o_stamp_value <= 16'h0;
			stamp_ff <= 16'h0;
		end
		else
		begin
			osc_sync_ff <= {osc_sync_ff[1:0], i_osc_clk};
			rx_sync_ff <= {rx_sync_ff[1:0], i_rx_line};
			if (osc_sync_ff[2] == osc_sync_ff[1])
				osc_level_ff <= osc_sync_ff[2];
			if (rx_sync_ff[2] == rx_sync_ff[1])
				rx_level_ff <= rx_sync_ff[2];
			o_tq_tick <= 1'b0;
			o_sample_tick <= 1'b0;
			o_jump_width_tq <= {1'b0, timing_a_ff[7:6]} + 3'h1;
			if (src_tick)
			begin
				if (presc_ff >= timing_a_ff[5:0])
				begin
					presc_ff <= 6'h0;
					o_tq_tick <= 1'b1;
					if (tq_cnt_ff >= bit_end)
						tq_cnt_ff <= 5'h0;
					else
						tq_cnt_ff <= tq_cnt_ff + 5'h1;
					o_sync_seg <= (tq_cnt_ff >= bit_end);
					if (tq_cnt_ff + 5'h2 >= seg1_end && tq_cnt_ff <= seg1_end)
						samp_hist_ff <= {samp_hist_ff[1:0], rx_level_ff};
					if (tq_cnt_ff == seg1_end)
					begin
						o_sample_tick <= 1'b1;
						if (timing_b_ff[`TB_SAMP])
							o_rx_sample <= (samp_hist_ff[1] & samp_hist_ff[0]) | (samp_hist_ff[1] & rx_level_ff)
								| (samp_hist_ff[0] & rx_level_ff);
						else
							o_rx_sample <= rx_level_ff;
					end
				end
				else
					presc_ff <= presc_ff + 6'h1;
			end
			o_tx_line <= (control_a_ff[`CA_INIT_REQ] | i_power_down | ~control_b_ff[`CB_ENABLE]) ? 1'b1 : i_tx_bit;
			o_rx_shift <= accept & (filter_mode_ff[5:4] != `FM_CLOSED);
			o_stamp_rx <= control_a_ff[`CA_TIME_EN] & accept;
			o_stamp_tx <= control_a_ff[`CA_TIME_EN] & i_tx_frame_ok;
			if (control_a_ff[`CA_TIME_EN] && (accept || i_tx_frame_ok))
			begin
				o_stamp_value <= i_timer;
				stamp_ff <= i_timer;
			end
		end
	end

endmodule

// >>> can_filter_timing_monitor.sv
// port checker for the filter and timing block
// assumes it is bound onto can_filter_timing
`timescale 1ns/1ps
module can_filter_timing_monitor
(
	// clock, reset
	input wire i_ref_clk,
	input wire i_reset_n,
	// bus
	input wire i_psel,
	input wire i_penable,
	input wire o_pready,
	// line and frames
	input wire i_power_down,
	input wire o_tx_line,
	input wire i_rx_frame_ok,
	input wire i_rx_buf_free,
	input wire o_rx_shift,
	input wire i_tx_frame_ok,
	input wire o_stamp_rx,
	input wire o_stamp_tx,
	// bit timing
	input wire o_sample_tick,
	input wire o_sync_seg,
	input wire [2:0] o_jump_width_tq
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_reset_n);
	property p_ready;
		i_psel && !i_penable |=> o_pready;
	endproperty
	a_ready: assert property (p_ready) else $error("ready late");
	property p_once;
		o_pready |=> !o_pready;
	endproperty
	a_once: assert property (p_once) else $error("ready held");
	property p_tx;
		i_power_down |=> o_tx_line;
	endproperty
	a_tx: assert property (p_tx) else $error("tx not recessive");
	property p_shift;
		o_rx_shift |-> $past(i_rx_frame_ok && i_rx_buf_free);
	endproperty
	a_shift: assert property (p_shift) else $error("shift without frame");
	property p_srx;
		o_stamp_rx |-> $past(i_rx_frame_ok);
	endproperty
	a_srx: assert property (p_srx) else $error("rx stamp without frame");
	property p_stx;
		o_stamp_tx |-> $past(i_tx_frame_ok);
	endproperty
	a_stx: assert property (p_stx) else $error("tx stamp without frame");
	property p_jw;
		o_jump_width_tq >= 3'h1 && o_jump_width_tq <= 3'h4;
	endproperty
	a_jw: assert property (p_jw) else $error("jump width range");
	property p_sync;
		o_sample_tick |-> !o_sync_seg;
	endproperty
	a_sync: assert property (p_sync) else $error("sample in sync");
	c_shift: cover property (o_rx_shift);
	c_stx: cover property (o_stamp_tx);
	c_tick: cover property (o_sample_tick);
endmodule
bind can_filter_timing can_filter_timing_monitor mon
(
	.i_ref_clk, .i_reset_n, .i_psel, .i_penable, .o_pready, .i_power_down, .o_tx_line,
	.i_rx_frame_ok, .i_rx_buf_free, .o_rx_shift, .i_tx_frame_ok, .o_stamp_rx, .o_stamp_tx,
	.o_sample_tick, .o_sync_seg, .o_jump_width_tq
);

// >>> can_bus_model.sv
// bus line: wired-and of this node and the other nodes
// assumes 1 is recessive and the line idles recessive
`timescale 1ns/1ps
module can_bus_model
(
	// node bits
	input wire i_tx_line,
	input wire i_other_bit,
	// resolved level
	output wire o_bus
);
	assign o_bus = i_tx_line & i_other_bit;
endmodule

// >>> can_filter_timing_test.sv
// self-checking bench for the filter and timing block
// assumes the bus model and the monitor are compiled first
`timescale 1ns/1ps
`include "can_filter_timing_consts.vh"
module can_filter_timing_test;
	reg clk = 1'h0, i_reset_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
	reg rxok = 1'h0, txok = 1'h0, pd = 1'h0, txb = 1'h1;
	reg [11:0] pa = 12'h000;
	reg [31:0] pwd = 32'h0, rid = 32'h0, rnd = 32'h388BAB15, prd;
	reg [31:0] pat [0:1];
	reg [31:0] msk [0:1];
	reg [7:0] rec = 8'h00, tec = 8'h00, ta, tb;
	reg [15:0] tmr = 16'h0000;
	wire [31:0] prdata;
	wire [15:0] sval;
	wire [2:0] jw;
	wire pready, txl, rxl, shift, stx, stk;
	integer err_total = 0, comparisons = 0, i, m, n;
	can_filter_timing dut
	(
		.i_ref_clk(clk), .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(pa), .i_pwdata(pwd), .o_prdata(prdata), .o_pready(pready), .o_pslverr(),
		.i_osc_clk(1'h0), .i_special_mode(1'h0), .i_power_down(pd), .i_rx_id_word(rid),
		.i_rx_frame_ok(rxok), .i_tx_frame_ok(txok), .i_rx_buf_free(1'h1), .i_tx_bit(txb),
		.i_rx_line(rxl), .i_rx_err_cnt(rec), .i_tx_err_cnt(tec), .i_timer(tmr), .o_tx_line(txl),
		.o_rx_shift(shift), .o_stamp_rx(), .o_stamp_tx(stx), .o_stamp_value(sval), .o_tq_tick(),
		.o_sample_tick(stk), .o_sync_seg(), .o_rx_sample(), .o_jump_width_tq(jw)
	);
	can_bus_model bus (.i_tx_line(txl), .i_other_bit(1'h1), .o_bus(rxl));
	always #20 clk = ~clk;
	function [31:0] xs(input [31:0] v);
		reg [31:0] t;
		begin
			t = v ^ (v << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	// {accept, index} of the lowest matching filter
	function [3:0] hit(input [1:0] md, input [31:0] id);
		integer f, w;
		reg [63:0] d;
		begin
			hit = 4'h0;
			w = 32 >> md;
			d = {pat[0], pat[1]} ^ (md == 2'h0 ? {id, id} : md == 2'h1 ? {4{id[31:16]}} : {8{id[31:24]}});
			d = d & ~{msk[0], msk[1]};
			for (f = 64 / w - 1; f >= 0; f = f - 1)
				if (md != 2'h3 && ((d << (f * w)) >> (64 - w)) == 64'h0)
					hit = {1'h1, f[2:0]};
		end
	endfunction
	task give_verdict;
		begin
			$display("comparisons %0d mismatches %0d", comparisons, err_total);
			if (err_total == 0 && comparisons > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
		begin
			comparisons = comparisons + 1;
			if (g !== e)
			begin
				err_total = err_total + 1;
				$display("Error %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		integer k;
		begin
			psel <= 1'h1;
			pwr <= w;
			pa <= a;
			pwd <= d;
			@(posedge clk);
			pen <= 1'h1;
			k = 0;
			@(posedge clk);
			while (pready !== 1'h1 && k < 9)
			begin
				k = k + 1;
				@(posedge clk);
			end
			if (k == 9)
			begin
				err_total = err_total + 1;
				give_verdict;
			end
			prd = prdata;
			psel <= 1'h0;
			pen <= 1'h0;
			@(posedge clk);
		end
	endtask
	task rdchk(input [11:0] a, input [63:0] nm, input [31:0] e);
		begin
			apb(1'h0, a, 32'h0);
			chk(nm, e, prd);
		end
	endtask
	task frame(input [31:0] id);
		reg [3:0] e;
		begin
			e = hit(m[1:0], id);
			@(posedge clk);
			rid <= id;
			rxok <= 1'h1;
			tmr <= id[15:0];
			@(posedge clk);
			rxok <= 1'h0;
			@(negedge clk);
			chk("shift", e[3], shift);
			if (e[3])
				chk("stamp", tmr, sval);
			@(posedge clk);
			rdchk(`OFS_RX_FLAG, "flag", e[3]);
			apb(1'h0, `OFS_FILTER_MODE, 32'h0);
			if (e[3])
				chk("hit", e[2:0], prd[2:0]);
			apb(1'h1, `OFS_RX_FLAG, 32'h1);
		end
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		i_reset_n <= 1'h1;
		txb <= 1'h0;
		rdchk(`OFS_CONTROL_A, "ctla", `RST_CONTROL_A);
		rdchk(`OFS_CONTROL_B, "ctlb", `RST_CONTROL_B);
		rdchk(`OFS_TIMING_A, "tima", `RST_TIMING);
		rdchk(`OFS_FILTER_MODE, "mode", `RST_FILTER_MODE);
		chk("inittx", 1, txl);
		txb <= 1'h1;
		rnd = xs(rnd);
		rec <= rnd[7:0];
		tec <= rnd[15:8];
		apb(1'h1, `OFS_RX_ERR, ~rnd);
		apb(1'h1, `OFS_TX_ERR, ~rnd);
		rdchk(`OFS_RX_ERR, "rxerr", rnd[7:0]);
		rdchk(`OFS_TX_ERR, "txerr", rnd[15:8]);
		ta = {rnd[17:16], 3'h0, rnd[20:18]};
		tb = {rnd[21], 1'h1, rnd[23:22], 1'h1, rnd[26:24]};
		apb(1'h1, `OFS_CONTROL_B, 32'hC0);
		apb(1'h1, `OFS_TIMING_A, {24'h0, ta});
		apb(1'h1, `OFS_TIMING_B, {24'h0, tb});
		apb(1'h1, `OFS_CONTROL_B, 32'h40);
		rdchk(`OFS_CONTROL_B, "ctlb", 32'hC1);
		chk("enable", 2'h3, prd[7:6]);
		chk("jw", ta[7:6] + 3'h1, jw);
		apb(1'h1, `OFS_CONTROL_A, 32'h8);
		$display("registers done");
		n = 0;
		while (stk !== 1'h1 && n < 3000)
		begin
			n = n + 1;
			@(negedge clk);
		end
		n = 1;
		@(negedge clk);
		while (stk !== 1'h1 && n < 3000)
		begin
			n = n + 1;
			@(negedge clk);
		end
		if (n >= 3000)
			err_total = err_total + 1;
		chk("bit", (ta[5:0] + 1) * (tb[3:0] + tb[6:4] + 3), n);
		@(posedge clk);
		txb <= 1'h0;
		repeat (2) @(posedge clk);
		chk("txon", 0, txl);
		pd <= 1'h1;
		repeat (2) @(posedge clk);
		chk("pdtx", 1, txl);
		pd <= 1'h0;
		txb <= 1'h1;
		apb(1'h1, `OFS_TIMING_A, {24'h0, ~ta});
		rdchk(`OFS_TIMING_A, "lock", ta);
		$display("timing done");
		for (m = 0; m < 4; m = m + 1)
		begin
			apb(1'h1, `OFS_CONTROL_A, 32'h9);
			for (i = 0; i < 2; i = i + 1)
			begin
				rnd = xs(rnd);
				pat[i] = rnd;
				rnd = xs(rnd);
				msk[i] = rnd | xs(rnd);
				apb(1'h1, `OFS_PATTERN_LO + {i[9:0], 2'h0}, pat[i]);
				apb(1'h1, `OFS_MASK_LO + {i[9:0], 2'h0}, msk[i]);
			end
			apb(1'h1, `OFS_FILTER_MODE, {26'h0, m[1:0], 4'h0});
			apb(1'h1, `OFS_CONTROL_A, 32'h8);
			for (n = 0; n < 8; n = n + 1)
			begin
				rnd = xs(rnd);
				frame(n[0] ? rnd : pat[rnd[0]] ^ (rnd & msk[rnd[0]]));
			end
		end
		$display("filters done");
		@(posedge clk);
		txok <= 1'h1;
		tmr <= rnd[31:16];
		@(posedge clk);
		txok <= 1'h0;
		@(negedge clk);
		chk("txstamp", 1, stx);
		chk("txval", tmr, sval);
		give_verdict;
	end
endmodule
